// ### hdl/sss_defs.svh
// Constants for the spherical shot sequencer
`ifndef SSS_DEFS_SVH
`define SSS_DEFS_SVH
`define SSS_CLK_HZ 100000000
`define SSS_TICK_MS 100
`define SSS_TICK_CYC ((`SSS_CLK_HZ / 1000) * `SSS_TICK_MS)
`define SSS_TIME_W 16
`define SSS_ROWS_W 4
`define SSS_COLS_W 8
`define SSS_ANG_W 16
`define SSS_MIN_ROWS 4'h3
`define SSS_MIN_MID_COLS 8'h02
`define SSS_ZENITH 16'h0384
`define SSS_NADIR 16'hFC7C
`define SSS_FULL_CIRCLE 16'h0E10
`define SSS_HALF_CIRCLE 16'h0708
`define SSS_RST_RELEASE 16'h0001
`define SSS_RST_SPHERES 16'h0001
`define SSS_MAX_ROWS 16
`define SSS_A_FOCUS 8'h00
`define SSS_A_RELEASE 8'h01
`define SSS_A_DELAY 8'h02
`define SSS_A_STILL 8'h03
`define SSS_A_ROWS 8'h04
`define SSS_A_SPHERES 8'h05
`define SSS_A_CTRL 8'h06
`define SSS_A_STATUS 8'h07
`define SSS_A_PAN 8'h08
`define SSS_A_TILT 8'h09
`define SSS_A_COLS 8'h10
`define SSS_C_START 0
`define SSS_C_RETURN 1
`define SSS_C_SLIDER 2
`define SSS_C_ABORT 3
`endif

// ### hdl/sss_pkg.sv
// Types for the spherical shot sequencer
`default_nettype none
package sss_pkg;
    typedef enum logic [3:0] {
        SSS_IDLE, SSS_FOCUS, SSS_RELEASE, SSS_DELAY, SSS_MOVE,
        SSS_STILL, SSS_RETURN, SSS_SLIDE, SSS_NEXT
    } sss_state_t;
endpackage
`default_nettype wire

// ### hdl/sss_timer.sv
// Duration counter in 0.1 s steps
`include "sss_defs.svh"
`default_nettype none
module sss_timer (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [`SSS_TIME_W-1:0] steps,
    output logic busy,
    output logic done
);
    logic [23:0] tick_q;
    logic [`SSS_TIME_W-1:0] left_q;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || start)
        begin
            tick_q <= 24'h000000;
        end
        else if (busy)
        begin
            tick_q <= (tick_q == 24'(`SSS_TICK_CYC - 1)) ? 24'h000000 : tick_q + 24'h000001;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        done <= 1'b0;
        if (sys_rst)
        begin
            left_q <= '0;
            busy <= 1'b0;
        end
        else if (start)
        begin
            left_q <= steps;
            busy <= (steps != '0);
            done <= (steps == '0);
        end
        else if (busy && tick_q == 24'(`SSS_TICK_CYC - 1))
        begin
            left_q <= left_q - 1'b1;
            if (left_q == 16'h0001)
            begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
    end
endmodule // sss_timer
`default_nettype wire

// ### hdl/sss_pan_step.sv
// Pan step of 360/N in tenths of a degree
`include "sss_defs.svh"
`default_nettype none
module sss_pan_step (
    input wire logic [`SSS_COLS_W-1:0] cols,
    output logic [`SSS_ANG_W-1:0] step
);
    always_comb
    begin
        step = (cols == '0) ? '0 : `SSS_ANG_W'(`SSS_FULL_CIRCLE / {8'h00, cols});
    end
endmodule // sss_pan_step
`default_nettype wire

// ### hdl/sss_top.sv
// Spherical shot sequencer: camera timing and pan/tilt stepping
`include "sss_defs.svh"
`default_nettype none
module sss_top (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic motor_done,
    output logic cam_focus,
    output logic cam_release,
    output logic motor_go,
    output logic [`SSS_ANG_W-1:0] pan_target,
    output logic [`SSS_ANG_W-1:0] tilt_target,
    output logic slider_step,
    output logic busy
);
    logic [`SSS_TIME_W-1:0] focus_q, release_q, delay_q, still_q;
    logic [`SSS_ROWS_W-1:0] rows_q;
    logic [`SSS_TIME_W-1:0] spheres_q;
    logic ret_en_q, slide_en_q, refused_q;
    logic [`SSS_COLS_W-1:0] cols_q [`SSS_MAX_ROWS];
    sss_pkg::sss_state_t state_q;
    logic [`SSS_ROWS_W-1:0] row_q;
    logic [`SSS_COLS_W-1:0] col_q;
    logic [`SSS_TIME_W-1:0] sphere_q;
    logic t_start;
    logic [`SSS_TIME_W-1:0] t_steps;
    logic t_busy, t_done;
    logic [`SSS_ANG_W-1:0] pan_step;
    logic [`SSS_COLS_W-1:0] cur_cols;
    logic wr_start, wr_abort, cfg_ok;
    logic last_img, last_row;

    // Legal shot count for a row
    function automatic logic cols_legal(input logic [`SSS_ROWS_W-1:0] r,
                                        input logic [`SSS_ROWS_W-1:0] n,
                                        input logic [`SSS_COLS_W-1:0] c);
        cols_legal = (r == '0 || r == n - 1'b1) || (c >= `SSS_MIN_MID_COLS);
    endfunction

    // Tilt angle of a row, evenly from zenith to nadir
    function automatic logic [`SSS_ANG_W-1:0] row_angle(input logic [`SSS_ROWS_W-1:0] r,
                                                        input logic [`SSS_ROWS_W-1:0] n);
        logic [`SSS_ANG_W-1:0] span;
        span = `SSS_ANG_W'(({12'h000, r} * `SSS_HALF_CIRCLE) / {12'h000, n - 1'b1});
        row_angle = `SSS_ZENITH - span;
    endfunction

    sss_timer u_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .start(t_start),
        .steps(t_steps),
        .busy(t_busy),
        .done(t_done)
    );

    assign cur_cols = cols_q[row_q];

    sss_pan_step u_pan_step (
        .cols(cur_cols),
        .step(pan_step)
    );

    always_comb
    begin
        cfg_ok = (rows_q >= `SSS_MIN_ROWS);
        for (int i = 0; i < `SSS_MAX_ROWS; i++)
        begin
            if (`SSS_ROWS_W'(i) < rows_q && !cols_legal(`SSS_ROWS_W'(i), rows_q, cols_q[i]))
            begin
                cfg_ok = 1'b0;
            end
        end
    end

    assign wr_start = reg_wr && reg_addr == `SSS_A_CTRL && reg_wdata[`SSS_C_START];
    assign wr_abort = reg_wr && reg_addr == `SSS_A_CTRL && reg_wdata[`SSS_C_ABORT];
    assign last_row = (row_q == rows_q - 1'b1);
    assign last_img = (col_q + 1'b1 >= cur_cols);

    // Configuration, frozen while running
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            focus_q <= '0;
            release_q <= `SSS_RST_RELEASE;
            delay_q <= '0;
            still_q <= '0;
            rows_q <= `SSS_MIN_ROWS;
            spheres_q <= `SSS_RST_SPHERES;
            ret_en_q <= 1'b0;
            slide_en_q <= 1'b0;
        end
        else if (reg_wr && state_q == sss_pkg::SSS_IDLE)
        begin
            unique case (reg_addr)
                `SSS_A_FOCUS: focus_q <= reg_wdata[`SSS_TIME_W-1:0];
                `SSS_A_RELEASE: release_q <= reg_wdata[`SSS_TIME_W-1:0];
                `SSS_A_DELAY: delay_q <= reg_wdata[`SSS_TIME_W-1:0];
                `SSS_A_STILL: still_q <= reg_wdata[`SSS_TIME_W-1:0];
                `SSS_A_ROWS:
                begin
                    if (reg_wdata[`SSS_ROWS_W-1:0] >= `SSS_MIN_ROWS)
                    begin
                        rows_q <= reg_wdata[`SSS_ROWS_W-1:0];
                    end
                end
                `SSS_A_SPHERES: spheres_q <= reg_wdata[`SSS_TIME_W-1:0];
                `SSS_A_CTRL:
                begin
                    ret_en_q <= reg_wdata[`SSS_C_RETURN];
                    slide_en_q <= reg_wdata[`SSS_C_SLIDER];
                end
                default: ;
            endcase
        end
    end

    // Per-row shot counts
    generate
        for (genvar g = 0; g < `SSS_MAX_ROWS; g++)
        begin : g_cols
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                begin
                    cols_q[g] <= `SSS_MIN_MID_COLS;
                end
                else if (reg_wr && state_q == sss_pkg::SSS_IDLE &&
                         reg_addr == `SSS_A_COLS + 8'(g))
                begin
                    cols_q[g] <= reg_wdata[`SSS_COLS_W-1:0];
                end
            end
        end
    endgenerate

    // Refusal flag: set wins over clear
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            refused_q <= 1'b0;
        end
        else if ((reg_wr && state_q == sss_pkg::SSS_IDLE && reg_addr == `SSS_A_ROWS &&
                  reg_wdata[`SSS_ROWS_W-1:0] < `SSS_MIN_ROWS) ||
                 (wr_start && state_q == sss_pkg::SSS_IDLE && !cfg_ok))
        begin
            refused_q <= 1'b1;
        end
        else if (reg_rd && reg_addr == `SSS_A_STATUS)
        begin
            refused_q <= 1'b0;
        end
    end

    // Timer launch for each timed phase
    always_comb
    begin
        t_steps = '0;
        unique case (state_q)
            sss_pkg::SSS_FOCUS: t_steps = release_q;
            sss_pkg::SSS_RELEASE: t_steps = delay_q;
            sss_pkg::SSS_MOVE: t_steps = still_q;
            default: t_steps = focus_q;
        endcase
        t_start = (state_q == sss_pkg::SSS_NEXT) ||
                  (state_q == sss_pkg::SSS_FOCUS && t_done) ||
                  (state_q == sss_pkg::SSS_RELEASE && t_done) ||
                  (state_q == sss_pkg::SSS_MOVE && motor_done && !motor_go);
    end

    // Sequencer
    always_ff @(posedge ref_clk)
    begin
        motor_go <= 1'b0;
        slider_step <= 1'b0;
        if (sys_rst || wr_abort)
        begin
            state_q <= sss_pkg::SSS_IDLE;
            row_q <= '0;
            col_q <= '0;
            sphere_q <= '0;
            if (sys_rst)
            begin
                pan_target <= '0;
                tilt_target <= `SSS_ZENITH;
            end
        end
        else
        begin
            unique case (state_q)
                sss_pkg::SSS_IDLE:
                begin
                    if (wr_start && cfg_ok)
                    begin
                        row_q <= '0;
                        col_q <= '0;
                        sphere_q <= '0;
                        pan_target <= '0;
                        tilt_target <= `SSS_ZENITH;
                        motor_go <= 1'b1;
                        state_q <= sss_pkg::SSS_MOVE;
                    end
                end
                sss_pkg::SSS_NEXT: state_q <= sss_pkg::SSS_FOCUS;
                sss_pkg::SSS_FOCUS:
                begin
                    if (t_done)
                        state_q <= sss_pkg::SSS_RELEASE;
                end
                sss_pkg::SSS_RELEASE:
                begin
                    if (t_done)
                        state_q <= sss_pkg::SSS_DELAY;
                end
                sss_pkg::SSS_DELAY:
                begin
                    if (!t_busy)
                    begin
                        if (!last_img && cur_cols != '0)
                        begin
                            col_q <= col_q + 1'b1;
                            pan_target <= pan_target + pan_step;
                            motor_go <= 1'b1;
                            state_q <= sss_pkg::SSS_MOVE;
                        end
                        else if (!last_row)
                        begin
                            row_q <= row_q + 1'b1;
                            col_q <= '0;
                            tilt_target <= row_angle(row_q + 1'b1, rows_q);
                            motor_go <= 1'b1;
                            state_q <= sss_pkg::SSS_MOVE;
                        end
                        else if (ret_en_q)
                        begin
                            pan_target <= '0;
                            tilt_target <= `SSS_ZENITH;
                            motor_go <= 1'b1;
                            state_q <= sss_pkg::SSS_RETURN;
                        end
                        else
                        begin
                            state_q <= sss_pkg::SSS_SLIDE;
                        end
                    end
                end
                sss_pkg::SSS_MOVE:
                begin
                    if (motor_done && !motor_go)
                        state_q <= sss_pkg::SSS_STILL;
                end
                sss_pkg::SSS_STILL:
                begin
                    if (!t_busy)
                        state_q <= (cur_cols == '0) ? sss_pkg::SSS_DELAY : sss_pkg::SSS_NEXT;
                end
                sss_pkg::SSS_RETURN:
                begin
                    if (motor_done && !motor_go)
                        state_q <= sss_pkg::SSS_SLIDE;
                end
                sss_pkg::SSS_SLIDE:
                begin
                    if (sphere_q + 1'b1 >= spheres_q)
                    begin
                        state_q <= sss_pkg::SSS_IDLE;
                    end
                    else
                    begin
                        slider_step <= slide_en_q;
                        sphere_q <= sphere_q + 1'b1;
                        row_q <= '0;
                        col_q <= '0;
                        pan_target <= '0;
                        tilt_target <= `SSS_ZENITH;
                        motor_go <= 1'b1;
                        state_q <= sss_pkg::SSS_MOVE;
                    end
                end
                default: state_q <= sss_pkg::SSS_IDLE;
            endcase
        end
    end

    // Camera outputs follow phase and timer
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cam_focus <= 1'b0;
            cam_release <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            cam_focus <= (state_q == sss_pkg::SSS_NEXT && focus_q != '0) ||
                         (state_q == sss_pkg::SSS_FOCUS && !t_done);
            cam_release <= (state_q == sss_pkg::SSS_FOCUS && t_done && release_q != '0) ||
                           (state_q == sss_pkg::SSS_RELEASE && !t_done);
            busy <= (state_q != sss_pkg::SSS_IDLE);
        end
    end

    // Register read, data one cycle later
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 32'h00000000;
        end
        else
        begin
            reg_rdata <= 32'h00000000;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    `SSS_A_FOCUS: reg_rdata <= {16'h0000, focus_q};
                    `SSS_A_RELEASE: reg_rdata <= {16'h0000, release_q};
                    `SSS_A_DELAY: reg_rdata <= {16'h0000, delay_q};
                    `SSS_A_STILL: reg_rdata <= {16'h0000, still_q};
                    `SSS_A_ROWS: reg_rdata <= {28'h0000000, rows_q};
                    `SSS_A_SPHERES: reg_rdata <= {16'h0000, spheres_q};
                    `SSS_A_CTRL: reg_rdata <= {29'h00000000, slide_en_q, ret_en_q, 1'b0};
                    `SSS_A_STATUS: reg_rdata <= {sphere_q, 4'h0, row_q, 2'h0, cfg_ok,
                                                 refused_q, 4'(state_q)};
                    `SSS_A_PAN: reg_rdata <= {16'h0000, pan_target};
                    `SSS_A_TILT: reg_rdata <= {16'h0000, tilt_target};
                    default:
                    begin
                        if (reg_addr[7:4] == 4'h1)
                        begin
                            reg_rdata <= {24'h000000, cols_q[reg_addr[3:0]]};
                        end
                    end
                endcase
            end
        end
    end
endmodule // sss_top
`default_nettype wire

// ### verif/sss_top_asserts.sv
// Port checker for the spherical shot sequencer
`include "sss_defs.svh"
`default_nettype none
module sss_top_asserts (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic motor_done,
    input wire logic cam_focus,
    input wire logic cam_release,
    input wire logic motor_go,
    input wire logic [`SSS_ANG_W-1:0] pan_target,
    input wire logic [`SSS_ANG_W-1:0] tilt_target,
    input wire logic slider_step,
    input wire logic busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_cam_quiet;
        !cam_focus && !cam_release;
    endsequence
    sequence s_go;
        motor_go;
    endsequence
    AST_GO_PULSE: assert property (s_go |=> !motor_go)
        else $error("move start longer than one cycle");
    AST_GO_CAM_QUIET: assert property (s_go |-> s_cam_quiet)
        else $error("camera active while a move starts");
    AST_GO_SETTLE: assert property (s_go |=> s_cam_quiet [*3])
        else $error("camera active before the move settled");
    AST_CAM_EXCL: assert property (!(cam_focus && cam_release))
        else $error("focus and release active together");
    AST_IDLE_QUIET: assert property (!busy |-> !cam_focus && !cam_release && !slider_step)
        else $error("activity while idle");
    AST_TARGET_HOLD: assert property (!motor_go |-> $stable(pan_target) && $stable(tilt_target))
        else $error("target changed without a move start");
    AST_TILT_RANGE: assert property (s_go |-> $signed(tilt_target) >= $signed(16'hFC7C)
        && $signed(tilt_target) <= $signed(16'h0384))
        else $error("tilt target beyond zenith or nadir");
    AST_SLIDER_PULSE: assert property (slider_step |=> !slider_step)
        else $error("slider step longer than one cycle");
    AST_SLIDER_NO_CAM: assert property (slider_step |-> s_cam_quiet)
        else $error("camera active during slider step");
    AST_RDATA_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read answer cycle");
endmodule // sss_top_asserts
bind sss_top sss_top_asserts sss_top_asserts_inst (.ref_clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .motor_done, .cam_focus, .cam_release, .motor_go,
    .pan_target, .tilt_target, .slider_step, .busy);
`default_nettype wire

// ### verif/sss_motor_model.sv
// Pan/tilt motor driver model answering move starts
`default_nettype none
module sss_motor_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic motor_go,
    input wire logic slow,
    output logic motor_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            motor_done <= 1'b1;
            cnt_q <= 8'h00;
        end
        else if (motor_go)
        begin
            motor_done <= 1'b0;
            cnt_q <= slow ? 8'h28 : 8'h04;
        end
        else if (cnt_q != 8'h00)
        begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01)
                motor_done <= 1'b1;
        end
    end
endmodule // sss_motor_model
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the spherical shot sequencer
`include "sss_defs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic slow = 1'b0;
    logic [31:0] reg_rdata;
    logic motor_done, cam_focus, cam_release, motor_go, slider_step, busy;
    logic [15:0] pan_target, tilt_target;
    logic [15:0] pan_q[$];
    logic [15:0] tilt_q[$];
    int err_count = 0;
    int compares = 0;
    int slides = 0;
    int focus_cyc = 0;
    sss_top sss_top_inst (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .motor_done, .cam_focus, .cam_release, .motor_go, .pan_target,
        .tilt_target, .slider_step, .busy);
    sss_motor_model sss_motor_model_inst (.ref_clk, .sys_rst, .motor_go, .slow, .motor_done);
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        if (motor_go === 1'b1)
        begin
            pan_q.push_back(pan_target);
            tilt_q.push_back(tilt_target);
        end
        if (slider_step === 1'b1)
            slides++;
        if (cam_focus === 1'b1)
            focus_cyc++;
    end
    task automatic close_out();
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_busy(input logic lvl, input int bound);
        int i;
        for (i = 0; i < bound && busy !== lvl; i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        if (busy !== lvl)
        begin
            err_count++;
            close_out();
        end
    endtask
    // Pattern 1/4/1 over three rows, all times zero
    task automatic setup(input logic [31:0] spheres, input logic [31:0] flags);
        for (int r = 0; r < 4; r++)
            wr(r[7:0], 32'h0);
        wr(`SSS_A_ROWS, 32'h3);
        wr(`SSS_A_COLS, 32'h1);
        wr(`SSS_A_COLS + 8'h01, 32'h4);
        wr(`SSS_A_COLS + 8'h02, 32'h1);
        wr(`SSS_A_SPHERES, spheres);
        pan_q.delete();
        tilt_q.delete();
        slides = 0;
        wr(`SSS_A_CTRL, flags | 32'h1);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 20000);
    endtask
    task automatic t_reset();
        logic [31:0] d;
        chk(tilt_target, 32'h0384);
        chk(pan_target, 32'h0);
        chk(busy, 32'h0);
        rd(`SSS_A_ROWS, d);
        chk(d, 32'h3);
        rd(`SSS_A_SPHERES, d);
        chk(d, 32'h1);
        rd(8'hFF, d);
        chk(d, 32'h0);
    endtask
    task automatic t_refuse();
        logic [31:0] d;
        wr(`SSS_A_ROWS, 32'h2);
        rd(`SSS_A_ROWS, d);
        chk(d, 32'h3);
        rd(`SSS_A_STATUS, d);
        chk(d[4], 32'h1);
        rd(`SSS_A_STATUS, d);
        chk(d[4], 32'h0);
        wr(`SSS_A_COLS + 8'h01, 32'h1);
        wr(`SSS_A_CTRL, 32'h1);
        repeat (10) @(posedge ref_clk);
        #1 chk(busy, 32'h0);
        rd(`SSS_A_STATUS, d);
        chk(d[4], 32'h1);
    endtask
    task automatic t_single();
        int prev;
        int dlt;
        int nadir;
        setup(32'h1, 32'h0);
        chk(tilt_q.size() > 0, 32'h1);
        chk(tilt_q[0], 32'h0384);
        chk(tilt_q[1], 32'h0);
        prev = 0;
        nadir = 0;
        foreach (pan_q[i])
        begin
            dlt = (int'(pan_q[i]) - prev + 3600) % 3600;
            chk(dlt == 0 || dlt == 900, 32'h1);
            prev = int'(pan_q[i]);
            nadir += (tilt_q[i] === 16'hFC7C);
        end
        chk(nadir, 32'h1);
        chk(focus_cyc, 32'h0);
        chk(slides, 32'h0);
    endtask
    task automatic t_multi();
        int nadir;
        slow <= 1'b1;
        setup(32'h2, 32'h6);
        nadir = 0;
        foreach (tilt_q[i])
            nadir += (tilt_q[i] === 16'hFC7C);
        chk(nadir, 32'h2);
        chk(slides, 32'h1);
        chk(tilt_q[tilt_q.size() - 1], 32'h0384);
        chk(busy, 32'h0);
    endtask
    // Focus then release onset, cut short by abort
    task automatic t_abort();
        int n;
        wr(`SSS_A_FOCUS, 32'h1);
        wr(`SSS_A_RELEASE, 32'h1);
        for (int k = 0; k < 2; k++)
        begin
            wr(`SSS_A_CTRL, 32'h1);
            n = 0;
            while (cam_focus !== 1'b1 && cam_release !== 1'b1 && n < 200)
            begin
                @(posedge ref_clk);
                #1 n++;
            end
            repeat (20) @(posedge ref_clk);
            #1;
            chk(cam_focus, (k == 0) ? 32'h1 : 32'h0);
            chk(cam_release, (k == 0) ? 32'h0 : 32'h1);
            wr(`SSS_A_CTRL, 32'h8);
            @(posedge ref_clk);
            #1;
            chk({cam_focus, cam_release, busy}, 32'h0);
            wr(`SSS_A_FOCUS, 32'h0);
        end
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_refuse();
        t_single();
        t_multi();
        t_abort();
        close_out();
    end
endmodule // tb_top
`default_nettype wire
